//--- logic/ltcf_framer.sv
`timescale 1ns/1ps
`include "ltcf_defs.svh"

module ltcf_framer (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    rx_valid,
  input  wire logic                    rx_first,
  input  wire logic [7:0]              rx_octet,
  output logic                         tx_valid,
  input  wire logic                    tx_ready,
  output logic [7:0]                   tx_octet,
  output logic                         tx_last,
  input  wire logic                    allow_repeater,
  input  wire logic                    allow_all_class,
  input  wire logic                    fmt_8023_ok,
  input  wire logic                    fmt_8025_ok,
  input  wire logic                    deny_entry,
  input  wire logic                    redundancy_cap,
  input  wire logic                    mgmt_detected_duplicate_attr,
  input  wire logic                    list_wr,
  input  wire logic [`LTCF_LIST_IDX_W-1:0] list_idx,
  input  wire logic [`LTCF_ADDR_W-1:0] list_addr,
  input  wire logic                    list_valid,
  input  wire logic [`LTCF_ADDR_W-1:0] fwd_da,
  input  wire logic                    fwd_check,
  output logic                         fwd_deliver,
  output logic [`LTCF_ADDR_W-1:0]      port_addr,
  output logic                         port_active,
  output logic                         port_repeater,
  output logic                         port_all_class,
  output logic [1:0]                   port_format,
  output logic                         port_secondary,
  output logic                         link_test_only,
  output logic                         train_done,
  output logic                         train_reject
);

  ltcf_pkg::ltcf_state_t           state_q;
  logic [4:0]                      cnt_q;
  logic [`LTCF_HDR_W-1:0]          rx_hdr_q;
  logic [`LTCF_HDR_W-1:0]          tx_hdr_q;
  ltcf_pkg::ltcf_addr_t            list_q [`LTCF_LIST_DEPTH];
  logic [`LTCF_LIST_DEPTH-1:0]     list_v_q;
  logic [`LTCF_LIST_DEPTH-1:0]     hit;
  ltcf_pkg::ltcf_addr_t            rx_da;
  ltcf_pkg::ltcf_addr_t            rx_sa;
  ltcf_pkg::ltcf_cfg_t             rx_req;
  logic                            skip_dup;
  logic                            rx_take;
  logic                            tx_take;

  ltcf_cfg_if cfg ();

  // ----------------------------------------------------------------------------
  // Shared decode of an address: true for the all-zero null address.
  // ----------------------------------------------------------------------------
  function automatic logic addr_is_null(input ltcf_pkg::ltcf_addr_t a);
    addr_is_null = (a == `LTCF_NULL_ADDR);
  endfunction

  // ----------------------------------------------------------------------------
  // Header field views of the captured request.
  // ----------------------------------------------------------------------------
  assign rx_da  = rx_hdr_q[`LTCF_DA_MSB -: `LTCF_ADDR_W];
  assign rx_sa  = rx_hdr_q[`LTCF_SA_MSB -: `LTCF_ADDR_W];
  assign rx_req = rx_hdr_q[`LTCF_REQ_MSB -: `LTCF_CFG_W];
  assign rx_take = rx_valid && (state_q == ltcf_pkg::LTCF_ST_RX ||
                                (state_q == ltcf_pkg::LTCF_ST_IDLE && rx_first));
  assign tx_take = tx_valid && tx_ready;

  // ----------------------------------------------------------------------------
  // Sequencer: collect sixteen header octets, decide, then send the header back.
  // Octets beyond the header are not this block's concern and are dropped.
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ltcf_pkg::LTCF_ST_IDLE;
      cnt_q   <= 5'h00;
    end else begin
      case (state_q)
        ltcf_pkg::LTCF_ST_IDLE: begin
          if (rx_take) begin
            state_q <= ltcf_pkg::LTCF_ST_RX;
            cnt_q   <= 5'h01;
          end
        end
        ltcf_pkg::LTCF_ST_RX: begin
          if (rx_valid && rx_first) begin
            cnt_q <= 5'h01;
          end else if (rx_take) begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == `LTCF_LAST_OCTET) begin
              state_q <= ltcf_pkg::LTCF_ST_CALC;
            end
          end
        end
        ltcf_pkg::LTCF_ST_CALC: begin
          state_q <= ltcf_pkg::LTCF_ST_TX;
          cnt_q   <= 5'h00;
        end
        ltcf_pkg::LTCF_ST_TX: begin
          if (tx_take) begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == `LTCF_LAST_OCTET) begin
              state_q <= ltcf_pkg::LTCF_ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ltcf_pkg::LTCF_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Request capture, first octet on the wire lands in the top byte.
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_hdr_q <= '0;
    end else if (rx_take) begin
      rx_hdr_q <= {rx_hdr_q[`LTCF_HDR_W-9:0], rx_octet};
    end
  end

  // ----------------------------------------------------------------------------
  // Port address list kept by management; each valid entry is compared
  // against the trainer's source address.
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      list_v_q <= '0;
    end else if (list_wr) begin
      list_v_q[list_idx] <= list_valid;
    end
  end

  always_ff @(posedge clk) begin
    if (list_wr) begin
      list_q[list_idx] <= list_addr;
    end
  end

  // A null source never hits the list: an end node with it only tests the link.
  assign skip_dup = (redundancy_cap && rx_req[`LTCF_CFG_D]) || addr_is_null(rx_sa);

  genvar gi;
  generate
    for (gi = 0; gi < `LTCF_LIST_DEPTH; gi = gi + 1) begin : g_cmp
      assign hit[gi] = list_v_q[gi] && (list_q[gi] == rx_sa) && !skip_dup;
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Policy and request handed to the response calculator.
  // ----------------------------------------------------------------------------
  assign cfg.req_cfg                      = rx_req;
  assign cfg.src_addr                     = rx_sa;
  assign cfg.allow_repeater               = allow_repeater;
  assign cfg.allow_all_class              = allow_all_class;
  assign cfg.fmt_8023_ok                  = fmt_8023_ok;
  assign cfg.fmt_8025_ok                  = fmt_8025_ok;
  assign cfg.deny_entry                   = deny_entry;
  assign cfg.redundancy_cap               = redundancy_cap;
  assign cfg.dup_in_list                  = |hit;
  assign cfg.mgmt_detected_duplicate_attr = mgmt_detected_duplicate_attr;

  ltcf_resp_calc u_calc (
    .cfg (cfg.calc)
  );

  // ----------------------------------------------------------------------------
  // Response header: addresses and request echoed, received allowed field
  // dropped and replaced by the calculated one.
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_hdr_q <= '0;
    end else if (state_q == ltcf_pkg::LTCF_ST_CALC) begin
      tx_hdr_q <= {rx_hdr_q[`LTCF_HDR_W-1:`LTCF_CFG_W], cfg.alw_cfg};
    end else if (tx_take) begin
      tx_hdr_q <= {tx_hdr_q[`LTCF_HDR_W-9:0], 8'h00};
    end
  end

  assign tx_valid = (state_q == ltcf_pkg::LTCF_ST_TX);
  assign tx_octet = tx_hdr_q[`LTCF_HDR_W-1 -: 8];
  assign tx_last  = tx_valid && (cnt_q == `LTCF_LAST_OCTET);

  // ----------------------------------------------------------------------------
  // Port configuration latched when a response is built. A port is made
  // active only when the response admits the trainer.
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_addr      <= `LTCF_NULL_ADDR;
      port_active    <= 1'b0;
      port_repeater  <= 1'b0;
      port_all_class <= 1'b0;
      port_format    <= `LTCF_FF_8023;
      port_secondary <= 1'b0;
    end else if (state_q == ltcf_pkg::LTCF_ST_CALC) begin
      port_addr      <= rx_sa;
      port_active    <= cfg.admitted;
      port_repeater  <= cfg.alw_cfg[`LTCF_CFG_R];
      port_all_class <= cfg.alw_cfg[`LTCF_CFG_PP_HI:`LTCF_CFG_PP_LO] == `LTCF_PP_ALL;
      port_format    <= cfg.alw_cfg[`LTCF_CFG_FF_HI:`LTCF_CFG_FF_LO];
      port_secondary <= rx_req[`LTCF_CFG_D];
    end
  end

  // ----------------------------------------------------------------------------
  // Outcome pulses, one per response, plus a level that marks a node
  // that only exercised the link with the null address.
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      train_done     <= 1'b0;
      train_reject   <= 1'b0;
      link_test_only <= 1'b0;
    end else begin
      train_done   <= (state_q == ltcf_pkg::LTCF_ST_CALC) && cfg.admitted;
      train_reject <= (state_q == ltcf_pkg::LTCF_ST_CALC) && !cfg.admitted;
      if (state_q == ltcf_pkg::LTCF_ST_CALC) begin
        link_test_only <= !rx_req[`LTCF_CFG_R] && addr_is_null(rx_sa);
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Delivery decision for a frame offered to this port. Group frames go to
  // every active port whatever class was granted; unicast needs a match or
  // the receive-all class.
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fwd_deliver <= 1'b0;
    end else begin
      fwd_deliver <= fwd_check && port_active &&
                     (fwd_da[`LTCF_IG_BIT] || port_all_class ||
                      (fwd_da == port_addr));
    end
  end

endmodule

//--- shared/ltcf_defs.svh
// Notes on behaviour
// - Each address field is 48 bits wide.
// - Address bits: individual/group, universal/local, 46-bit address.
// - Null-address end node never counts as admitted.
// - Response echoes requested configuration unchanged.
// - Group frames reach every active port.
// - Reserved bits sent zero, ignored on receive.
// - Secondary link on a redundancy-capable repeater skips duplicate check, returns zero.
// - Secondary link on a redundancy-capable repeater clears duplicate bit despite management.
// - Protocol version field carries 001.
// - Allowed repeater bit: 0 node, 1 repeater.
// - Allowed class 00/10, allowed format 00/10.
// - Access-denied bit set only when refusing entry.
// - Incompatible bit set; fields show allowable configuration.
// - Duplicate bit set when address already listed.
`ifndef LTCF_DEFS_SVH
`define LTCF_DEFS_SVH

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define LTCF_ADDR_W      48
`define LTCF_CFG_W       16
`define LTCF_HDR_W       128
`define LTCF_HDR_OCTETS  5'h10
`define LTCF_LAST_OCTET  5'h0f
`define LTCF_DA_MSB      127
`define LTCF_SA_MSB      79
`define LTCF_REQ_MSB     31
`define LTCF_ALW_MSB     15
`define LTCF_IG_BIT      40
`define LTCF_UL_BIT      41
`define LTCF_NULL_ADDR   48'h0000_0000_0000

// ----------------------------------------------------------------------------
// Configuration field bit placement, shared by both ends of the link
// ----------------------------------------------------------------------------
`define LTCF_CFG_R       0
`define LTCF_CFG_PP_LO   1
`define LTCF_CFG_PP_HI   2
`define LTCF_CFG_FF_LO   3
`define LTCF_CFG_FF_HI   4
`define LTCF_CFG_N       5
`define LTCF_CFG_C       6
`define LTCF_CFG_D       8
`define LTCF_CFG_VER_LO  13
`define LTCF_CFG_VER_HI  15

// ----------------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------------
`define LTCF_PP_ADDRESSED 2'h0
`define LTCF_PP_ALL       2'h2
`define LTCF_FF_8023      2'h0
`define LTCF_FF_8025      2'h2
`define LTCF_FF_EITHER    2'h3
`define LTCF_VERSION      3'h1
`define LTCF_LIST_DEPTH   4
`define LTCF_LIST_IDX_W   2

`endif

//--- shared/ltcf_pkg.sv
`include "ltcf_defs.svh"

package ltcf_pkg;

  typedef enum logic [1:0] {
    LTCF_ST_IDLE,
    LTCF_ST_RX,
    LTCF_ST_CALC,
    LTCF_ST_TX
  } ltcf_state_t;

  typedef logic [`LTCF_ADDR_W-1:0] ltcf_addr_t;
  typedef logic [`LTCF_CFG_W-1:0]  ltcf_cfg_t;

endpackage

//--- shared/ltcf_cfg_if.sv
`timescale 1ns/1ps
`include "ltcf_defs.svh"

interface ltcf_cfg_if;
  ltcf_pkg::ltcf_cfg_t  req_cfg;
  ltcf_pkg::ltcf_addr_t src_addr;
  logic                 allow_repeater;
  logic                 allow_all_class;
  logic                 fmt_8023_ok;
  logic                 fmt_8025_ok;
  logic                 deny_entry;
  logic                 redundancy_cap;
  logic                 dup_in_list;
  logic                 mgmt_detected_duplicate_attr;
  ltcf_pkg::ltcf_cfg_t  alw_cfg;
  logic                 admitted;

  modport framer (
    output req_cfg,
    output src_addr,
    output allow_repeater,
    output allow_all_class,
    output fmt_8023_ok,
    output fmt_8025_ok,
    output deny_entry,
    output redundancy_cap,
    output dup_in_list,
    output mgmt_detected_duplicate_attr,
    input  alw_cfg,
    input  admitted
  );

  modport calc (
    input  req_cfg,
    input  src_addr,
    input  allow_repeater,
    input  allow_all_class,
    input  fmt_8023_ok,
    input  fmt_8025_ok,
    input  deny_entry,
    input  redundancy_cap,
    input  dup_in_list,
    input  mgmt_detected_duplicate_attr,
    output alw_cfg,
    output admitted
  );
endinterface

//--- logic/ltcf_resp_calc.sv
`timescale 1ns/1ps
`include "ltcf_defs.svh"

module ltcf_resp_calc (
  ltcf_cfg_if.calc cfg
);

  logic [1:0] req_pp;
  logic [1:0] req_ff;
  logic [1:0] alw_pp;
  logic [1:0] alw_ff;
  logic       req_rep;
  logic       alw_rep;
  logic       dup_bit;
  logic       mismatch;
  logic       null_node;
  logic       bad_src;
  logic       ver_bad;

  // ----------------------------------------------------------------------------
  // Field extraction; reserved request bits are never looked at.
  // ----------------------------------------------------------------------------
  assign req_rep = cfg.req_cfg[`LTCF_CFG_R];
  assign req_pp  = cfg.req_cfg[`LTCF_CFG_PP_HI:`LTCF_CFG_PP_LO];
  assign req_ff  = cfg.req_cfg[`LTCF_CFG_FF_HI:`LTCF_CFG_FF_LO];
  assign ver_bad = cfg.req_cfg[`LTCF_CFG_VER_HI:`LTCF_CFG_VER_LO] != `LTCF_VERSION;

  // ----------------------------------------------------------------------------
  // Role, unicast class and format that the repeater can actually grant.
  // A repeater must ask for the receive-all class, so it is given it whenever allow_all_class is set.
  // ----------------------------------------------------------------------------
  always_comb begin
    alw_rep = req_rep & cfg.allow_repeater;
    if ((req_pp == `LTCF_PP_ALL || req_rep) && cfg.allow_all_class) begin
      alw_pp = `LTCF_PP_ALL;
    end else begin
      alw_pp = `LTCF_PP_ADDRESSED;
    end
    if (req_ff == `LTCF_FF_8025 && cfg.fmt_8025_ok) begin
      alw_ff = `LTCF_FF_8025;
    end else if (cfg.fmt_8023_ok) begin
      alw_ff = `LTCF_FF_8023;
    end else if (cfg.fmt_8025_ok) begin
      alw_ff = `LTCF_FF_8025;
    end else begin
      alw_ff = `LTCF_FF_8023;
    end
  end

  // ----------------------------------------------------------------------------
  // Duplicate flag; a secondary link on a redundancy-capable repeater hides it.
  // ----------------------------------------------------------------------------
  always_comb begin
    if (cfg.redundancy_cap && cfg.req_cfg[`LTCF_CFG_D]) begin
      dup_bit = 1'b0;
    end else begin
      dup_bit = cfg.dup_in_list | cfg.mgmt_detected_duplicate_attr;
    end
  end

  // ----------------------------------------------------------------------------
  // Incompatibility: any requested field that could not be granted as asked.
  // ----------------------------------------------------------------------------
  assign null_node = !req_rep && cfg.src_addr == `LTCF_NULL_ADDR;
  assign bad_src   = cfg.src_addr[`LTCF_IG_BIT];
  always_comb begin
    mismatch = ver_bad | (req_rep != alw_rep);
    if (req_rep && alw_pp != `LTCF_PP_ALL) begin
      mismatch = 1'b1;
    end
    if (!req_rep && req_pp != alw_pp) begin
      mismatch = 1'b1;
    end
    if (req_ff != `LTCF_FF_EITHER && req_ff != alw_ff) begin
      mismatch = 1'b1;
    end
    // A fallback format that the port cannot carry is only a would-be grant.
    if ((alw_ff == `LTCF_FF_8023 && !cfg.fmt_8023_ok) ||
        (alw_ff == `LTCF_FF_8025 && !cfg.fmt_8025_ok)) begin
      mismatch = 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // Allowed field assembly; unassigned positions stay zero.
  // ----------------------------------------------------------------------------
  always_comb begin
    cfg.alw_cfg = '0;
    cfg.alw_cfg[`LTCF_CFG_R] = alw_rep;
    cfg.alw_cfg[`LTCF_CFG_PP_HI:`LTCF_CFG_PP_LO] = alw_pp;
    cfg.alw_cfg[`LTCF_CFG_FF_HI:`LTCF_CFG_FF_LO] = alw_ff;
    cfg.alw_cfg[`LTCF_CFG_N] = cfg.deny_entry;
    cfg.alw_cfg[`LTCF_CFG_C] = mismatch | null_node | bad_src | dup_bit;
    cfg.alw_cfg[`LTCF_CFG_D] = dup_bit;
    cfg.alw_cfg[`LTCF_CFG_VER_HI:`LTCF_CFG_VER_LO] = `LTCF_VERSION;
  end

  assign cfg.admitted = !(mismatch | null_node | bad_src | dup_bit | cfg.deny_entry);

endmodule

//--- verif/ltcf_framer_sva.sv
`timescale 1ns/1ps
`include "ltcf_defs.svh"

module ltcf_framer_sva (
  input wire logic                     clk,
  input wire logic                     reset,
  input wire logic                     tx_valid,
  input wire logic                     tx_ready,
  input wire logic [7:0]               tx_octet,
  input wire logic                     tx_last,
  input wire logic [`LTCF_ADDR_W-1:0]  fwd_da,
  input wire logic                     fwd_check,
  input wire logic                     fwd_deliver,
  input wire logic                     port_active,
  input wire logic [1:0]               port_format,
  input wire logic                     link_test_only,
  input wire logic                     train_done,
  input wire logic                     train_reject
);
  // -------------------------------------------------------------
  // Response stream, verdict, forwarding and port format checks
  // -------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_last_ends_frame: assert property (tx_last && tx_ready |=> !tx_valid)
    else $error("response ran past last octet");
  a_stalled_octet_holds: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_octet) && $stable(tx_last))
    else $error("response octet moved while stalled");
  a_verdict_single: assert property (
    train_done || train_reject |-> tx_valid && !tx_last ##1 !train_done && !train_reject)
    else $error("verdict pulse misplaced or too long");
  a_verdict_exclusive: assert property (train_done |-> !train_reject && port_active)
    else $error("admission verdict inconsistent");
  a_null_never_done: assert property (train_done |-> !link_test_only)
    else $error("null address node admitted");
  a_group_reaches_port: assert property (
    fwd_check && fwd_da[`LTCF_IG_BIT] && port_active |=> fwd_deliver)
    else $error("group frame withheld from active port");
  a_idle_port_silent: assert property (fwd_check && !port_active |=> !fwd_deliver)
    else $error("frame delivered to inactive port");
  a_format_legal: assert property (port_active |-> !port_format[0])
    else $error("reserved format code allowed");
endmodule

bind ltcf_framer ltcf_framer_sva ltcf_framer_sva_i (
  .clk(clk), .reset(reset), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_octet(tx_octet), .tx_last(tx_last), .fwd_da(fwd_da), .fwd_check(fwd_check),
  .fwd_deliver(fwd_deliver), .port_active(port_active), .port_format(port_format),
  .link_test_only(link_test_only), .train_done(train_done), .train_reject(train_reject)
);

//--- verif/ltcf_lower_model.sv
`timescale 1ns/1ps

module ltcf_lower_model (
  input  wire logic         clk,
  input  wire logic         start,
  input  wire logic [127:0] hdr,
  output logic              rx_valid,
  output logic              rx_first,
  output logic [7:0]        rx_octet,
  input  wire logic         tx_valid,
  output logic              tx_ready,
  input  wire logic [7:0]   tx_octet,
  input  wire logic         tx_last,
  output logic [127:0]      resp,
  output logic              resp_done
);
  integer seed = 32'h6fb9;

  // Octets go out first octet first with random gaps; an idle data line is
  // inverted so a stale octet can never pass for a fresh one.
  initial begin
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_octet = 8'h00;
    forever begin
      @(posedge clk);
      if (start) begin
        #1;
        for (int i = 15; i >= 0; i--) begin
          while ($random(seed) % 3 == 0) begin
            rx_valid = 1'b0;
            rx_octet = ~rx_octet;
            @(posedge clk);
            #1;
          end
          rx_valid = 1'b1;
          rx_first = (i == 15);
          rx_octet = hdr[i*8 +: 8];
          @(posedge clk);
          #1;
        end
        rx_valid = 1'b0;
        rx_first = 1'b0;
        rx_octet = ~rx_octet;
      end
    end
  end

  // The sink stalls at random so every response octet must hold.
  always @(posedge clk) begin
    #1 tx_ready = ($random(seed) % 4 != 0);
  end

  // Collect the response; done rises with the taken last octet.
  always @(posedge clk) begin
    if (start)
      resp_done <= 1'b0;
    else if (tx_valid && tx_ready) begin
      resp <= {resp[119:0], tx_octet};
      resp_done <= tx_last;
    end
  end
endmodule

//--- verif/test_link_training_config_fields.sv
`timescale 1ns/1ps
`include "ltcf_defs.svh"

module test_link_training_config_fields;
  logic         clk, reset, rx_valid, rx_first, tx_valid, tx_ready, tx_last;
  logic         list_wr, list_valid, fwd_check, fwd_deliver, port_active, port_repeater;
  logic         port_all_class, port_secondary, link_test_only, train_done, train_reject;
  logic         start, resp_done, ad;
  logic [1:0]   list_idx, port_format, saw;
  logic [7:0]   rx_octet, tx_octet;
  logic [6:0]   pol;
  logic [15:0]  ex;
  logic [47:0]  list_addr, fwd_da, port_addr, sa, lst [4];
  logic [127:0] hdr, resp;
  logic [31:0]  r;
  integer       seed, failures, n_compared;

  ltcf_framer ltcf_framer_i (.clk(clk), .reset(reset), .rx_valid(rx_valid),
    .rx_first(rx_first), .rx_octet(rx_octet), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_octet(tx_octet), .tx_last(tx_last), .allow_repeater(pol[6]),
    .allow_all_class(pol[5]), .fmt_8023_ok(pol[4]), .fmt_8025_ok(pol[3]),
    .deny_entry(pol[2]), .redundancy_cap(pol[1]), .mgmt_detected_duplicate_attr(pol[0]),
    .list_wr(list_wr), .list_idx(list_idx), .list_addr(list_addr), .list_valid(list_valid),
    .fwd_da(fwd_da), .fwd_check(fwd_check), .fwd_deliver(fwd_deliver),
    .port_addr(port_addr), .port_active(port_active), .port_repeater(port_repeater),
    .port_all_class(port_all_class), .port_format(port_format),
    .port_secondary(port_secondary), .link_test_only(link_test_only),
    .train_done(train_done), .train_reject(train_reject));

  ltcf_lower_model ltcf_lower_model_i (.clk(clk), .start(start), .hdr(hdr),
    .rx_valid(rx_valid), .rx_first(rx_first), .rx_octet(rx_octet), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_octet(tx_octet), .tx_last(tx_last), .resp(resp),
    .resp_done(resp_done));

  // -------------------------------------------------------------
  // Expectations and helpers
  // -------------------------------------------------------------
  function automatic logic [15:0] mkq(logic rp, logic [1:0] pp, logic [1:0] ff, logic d,
                                      logic [2:0] v);
    return {v, 4'h0, d, 3'h0, ff, pp, rp};
  endfunction

  // Allowed field per policy; list entries with bit 40 clear never match a group SA.
  function automatic logic [15:0] exp_alw(logic [15:0] q, logic [47:0] s, logic [6:0] p);
    logic dup, d, pa, c;
    logic [1:0] f;
    dup = 1'b0;
    for (int k = 0; k < 3; k++) dup |= (lst[k] == s) && (s != 48'h0);
    d = (dup | p[0]) & !(q[8] & p[1]);
    pa = (q[2] | q[0]) & p[5];
    f = (q[4:3] == 2'h3) ? {!p[4], 1'b0} : q[4:3];
    c = (q[15:13] != 3'h1) | (!q[0] & s == 48'h0) | s[40] | (q[0] & !(p[6] & pa))
      | (!q[0] & q[2] & !p[5]) | (f == 2'h0 & !p[4]) | (f == 2'h2 & !p[3]) | d;
    return {3'h1, 4'h0, d, 1'b0, c, p[2], f, pa, 1'b0, q[0] & p[6]};
  endfunction

  task automatic check(string what, logic [63:0] exp, logic [63:0] seen);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One training exchange; the format field is masked where the expected format cannot be carried,
  // since the would-be format is then a free choice of the repeater.
  task automatic run(logic [15:0] q, logic [47:0] s, logic [6:0] p);
    logic [15:0] m;
    int t;
    ex = exp_alw(q, s, p);
    ad = !ex[6] & !ex[5];
    m = (ex[6] && !(ex[4] ? p[3] : p[4])) ? 16'hffe7 : 16'hffff;
    pol = p;
    sa = s;
    hdr = {48'h0, s, q, 16'h0};
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    t = 0;
    while (!resp_done && t < 400) begin
      @(posedge clk);
      #1 t++;
    end
    check("done", 1, resp_done);
    check("echo", q, resp[31:16]);
    check("allowed", ex & m, resp[15:0] & m);
    check("verdict", {ad, !ad}, saw);
    check("active", ad, port_active);
    check("test_only", !q[0] && s == 48'h0, link_test_only);
    if (ad)
      check("port", {q[8], ex[4:0], s}, {port_secondary, port_format, port_all_class, 1'b0,
                                          port_repeater, port_addr});
  endtask

  task automatic fwd(logic [47:0] da, logic exp);
    @(posedge clk);
    #1 fwd_da = da;
    fwd_check = 1'b1;
    @(posedge clk);
    #1 fwd_check = 1'b0;
    check("deliver", exp, fwd_deliver);
  endtask

  task automatic tally_and_finish;
    if (failures == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // -------------------------------------------------------------
  // Clock, verdict capture, watchdog and main sequence
  // -------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Verdict pulses last one cycle, so they are latched here.
  always @(posedge clk) begin
    if (start) saw <= 2'h0;
    if (train_done) saw[1] <= 1'b1;
    if (train_reject) saw[0] <= 1'b1;
  end

  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end

  initial begin
    seed = 32'h6fb9;
    failures = 0;
    n_compared = 0;
    reset = 1'b1;
    start = 1'b0;
    hdr = '0;
    pol = 7'h78;
    list_wr = 1'b0;
    list_idx = 2'h0;
    list_addr = 48'h0;
    list_valid = 1'b0;
    fwd_da = 48'h0;
    fwd_check = 1'b0;
    repeat (20) @(posedge clk);
    #1 reset = 1'b0;
    for (int k = 0; k < 4; k++) begin
      lst[k] = {16'h0200 + 16'(k), $random(seed)};
      list_wr = 1'b1;
      list_idx = 2'(k);
      list_addr = lst[k];
      list_valid = (k != 3);
      @(posedge clk);
      #1;
    end
    list_wr = 1'b0;
    run(mkq(0, 2'h0, 2'h0, 0, 3'h1), lst[0], 7'h78);
    run(mkq(0, 2'h0, 2'h0, 1, 3'h1), lst[0], 7'h7a);
    run(mkq(0, 2'h0, 2'h0, 1, 3'h1), lst[1], 7'h78);
    run(mkq(0, 2'h2, 2'h3, 1, 3'h1), lst[3], 7'h7b);
    run(mkq(0, 2'h0, 2'h0, 0, 3'h1), lst[3], 7'h79);
    run(mkq(0, 2'h0, 2'h0, 0, 3'h1), 48'h0, 7'h78);
    run(mkq(1, 2'h2, 2'h3, 0, 3'h1), 48'h0, 7'h78);
    run(mkq(1, 2'h2, 2'h0, 0, 3'h2), lst[3], 7'h78);
    run(mkq(0, 2'h0, 2'h2, 0, 3'h1), lst[3] | 48'h0100_0000_0000, 7'h78);
    run(mkq(0, 2'h2, 2'h3, 0, 3'h1), lst[3], 7'h7c);
    run(mkq(1, 2'h0, 2'h3, 0, 3'h1) | 16'h1ee0, lst[3], 7'h50);
    run(mkq(0, 2'h0, 2'h3, 0, 3'h1), lst[3], 7'h74);
    run(mkq(0, 2'h2, 2'h0, 0, 3'h1), lst[3], 7'h68);
    for (int n = 0; n < 40; n++) begin
      r = $random(seed);
      run(mkq(r[0], {r[1] | r[0], 1'b0}, r[3:2] == 2'h1 ? 2'h3 : r[3:2], r[4], 3'h1),
          r[7:5] == 3'h0 ? lst[r[9:8]] : {16'h0200, $random(seed)},
          7'($random(seed)) & {6'h3f, r[11] & r[12]});
      fwd(r[13] ? sa : {7'h0, r[14], 8'h0, $random(seed)}, ad & (r[13] | r[14] | ex[2]));
      fwd({7'h0, r[15], 8'h0, $random(seed)}, ad & (r[15] | ex[2]));
    end
    tally_and_finish();
  end
endmodule
